// ===== plt_pkg.sv
// package: register map, field layout and constants of the lock-delay timer
package plt_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] CLOCK_MODE_OFFSET = 16'h0058;
  localparam int MUL_MSB = 15;
  localparam int MUL_LSB = 12;
  localparam int DIVF_BIT = 11;
  localparam int COUNT_MSB = 10;
  localparam int COUNT_LSB = 3;
  localparam int ONOFF_BIT = 2;
  localparam int NDIV_BIT = 1;
  localparam int STATUS_BIT = 0;
  localparam int COUNT_W = 8;
  localparam int PRESCALE_DIV = 16;
  localparam logic [3:0] MUL_RESET = 4'hF;
  localparam logic [3:0] MUL_QUARTER = 4'hF;
  localparam logic DIVF_RESET = 1'b0;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
  localparam logic ONOFF_RESET = 1'b0;
  localparam logic NDIV_RESET = 1'b1;

  typedef enum logic [1:0] {
    PLT_DIV  = 2'b00,
    PLT_LOCK = 2'b01,
    PLT_MULT = 2'b11
  } plt_mode_e;

  typedef struct packed {
    logic [3:0] mul;
    logic divFrac;
    logic [COUNT_W-1:0] lockDelayCount;
    logic pllOnOff;
    logic multNotDivSelect;
    logic status;
  } plt_clock_mode_s;
endpackage

// ===== plt_prescaler.sv
// divide-by-n tick generator with synchronous restart
`timescale 1ns/1ps
module plt_prescaler #(
  parameter int DIV = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  output logic tick
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt_r;

  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      cnt_r <= '0;
    end else if (cnt_r == LAST) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  // tick marks the last reference cycle of each group of DIV
  assign tick = (cnt_r == LAST) && !restart;
endmodule // plt_prescaler

// ===== plt_lock_timer.sv
// clock mode register, lock-delay down-counter and core clock selection
`timescale 1ns/1ps
module plt_lock_timer #(
  parameter int COUNT_W = plt_pkg::COUNT_W,
  parameter int PRESCALE_DIV = plt_pkg::PRESCALE_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [plt_pkg::ADDR_W-1:0] regAddr,
  input wire logic [plt_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [plt_pkg::DATA_W-1:0] regRdata,
  input wire logic multClockIn,
  output logic core_clock_out,
  output logic multClockSelect,
  output logic lockBusy
);
  plt_pkg::plt_clock_mode_s ctrl_r;
  plt_pkg::plt_clock_mode_s wrFields;
  plt_pkg::plt_mode_e mode_r;
  plt_pkg::plt_mode_e mode_nxt;
  logic [COUNT_W-1:0] lockCnt_r;
  logic [1:0] divCnt_r;
  logic [plt_pkg::DATA_W-1:0] regRdata_r;
  logic coreClock_r;
  logic hit;
  logic startLock;
  logic prescaleTick;

  assign wrFields = plt_pkg::plt_clock_mode_s'(regWdata);
  assign hit = (regAddr == plt_pkg::CLOCK_MODE_OFFSET);
  // only a div-to-mult change arms the timer; rewriting mult keeps running
  assign startLock = regWr && hit && wrFields.multNotDivSelect
                     && (mode_r == plt_pkg::PLT_DIV);

  plt_prescaler #(
    .DIV(PRESCALE_DIV)
  ) u_prescaler (
    .clk(clk),
    .rst_n(rst_n),
    .restart(startLock),
    .tick(prescaleTick)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r.mul <= plt_pkg::MUL_RESET;
      ctrl_r.divFrac <= plt_pkg::DIVF_RESET;
      ctrl_r.lockDelayCount <= plt_pkg::COUNT_RESET;
      ctrl_r.pllOnOff <= plt_pkg::ONOFF_RESET;
      ctrl_r.multNotDivSelect <= plt_pkg::NDIV_RESET;
      ctrl_r.status <= 1'b0;
    end else if (regWr && hit) begin
      ctrl_r <= wrFields;
      ctrl_r.status <= 1'b0;
    end
  end

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      plt_pkg::PLT_DIV: begin
        if (startLock) begin
          mode_nxt = plt_pkg::PLT_LOCK;
        end
      end
      plt_pkg::PLT_LOCK: begin
        if (regWr && hit && !wrFields.multNotDivSelect) begin
          mode_nxt = plt_pkg::PLT_DIV;
        end else if (lockCnt_r == '0) begin
          mode_nxt = plt_pkg::PLT_MULT;
        end
      end
      plt_pkg::PLT_MULT: begin
        // leaving mult mode needs no settling, so it is immediate
        if (regWr && hit && !wrFields.multNotDivSelect) begin
          mode_nxt = plt_pkg::PLT_DIV;
        end
      end
      default: begin
        mode_nxt = plt_pkg::PLT_DIV;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // reset comes up in mult mode, core clock taken from multClockIn
      mode_r <= plt_pkg::PLT_MULT;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lockCnt_r <= '0;
    end else if (startLock) begin
      lockCnt_r <= wrFields.lockDelayCount;
    end else if (mode_r == plt_pkg::PLT_LOCK && prescaleTick && lockCnt_r != '0) begin
      lockCnt_r <= lockCnt_r - COUNT_W'(1);
    end
  end

  // reference divided by 2, or by 4 when the multiplier field reads 15
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divCnt_r <= 2'h0;
    end else begin
      divCnt_r <= divCnt_r + 2'h1;
    end
  end

  assign multClockSelect = (mode_r == plt_pkg::PLT_MULT);
  assign lockBusy = (mode_r == plt_pkg::PLT_LOCK);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      coreClock_r <= 1'b0;
    end else if (mode_r == plt_pkg::PLT_MULT) begin
      coreClock_r <= multClockIn;
    end else if (ctrl_r.mul == plt_pkg::MUL_QUARTER) begin
      coreClock_r <= divCnt_r[1];
    end else begin
      coreClock_r <= divCnt_r[0];
    end
  end
  assign core_clock_out = coreClock_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdata_r <= 16'h0000;
    end else if (regRd && hit) begin
      regRdata_r <= {ctrl_r[plt_pkg::DATA_W-1:1], multClockSelect};
    end else begin
      regRdata_r <= 16'h0000;
    end
  end
  assign regRdata = regRdata_r;
endmodule // plt_lock_timer

// ===== plt_lock_timer_sva.sv
// checker of the lock-delay timer ports
`timescale 1ns/1ps
module plt_lock_timer_sva #(
  parameter int COUNT_W = 8,
  parameter int PRESCALE_DIV = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdata,
  input wire logic multClockIn,
  input wire logic core_clock_out,
  input wire logic multClockSelect,
  input wire logic lockBusy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire hit = regAddr == plt_pkg::CLOCK_MODE_OFFSET;
  rd_unmapped_a: assert property (regRd && !hit |=> regRdata == 16'h0000)
    else $error("unmapped read not zero");
  rd_status_a: assert property (regRd && hit |=> regRdata[0] == $past(multClockSelect))
    else $error("status bit wrong");
  lock_start_a: assert property (regWr && hit && regWdata[1] && !multClockSelect
    && !lockBusy |=> lockBusy && !multClockSelect) else $error("lock not started");
  busy_div_a: assert property (lockBusy |-> !multClockSelect)
    else $error("mult clock during lock");
  busy_min_a: assert property ($rose(lockBusy) && $past(regWdata[10:3]) != 8'h00
    |-> lockBusy [*8]) else $error("lock ended early");
  lock_end_a: assert property ($fell(lockBusy) && !$past(regWr) |-> multClockSelect)
    else $error("no mult after lock");
  mult_exit_a: assert property (regWr && hit && !regWdata[1]
    |=> !multClockSelect && !lockBusy) else $error("div not entered");
  mult_out_a: assert property (multClockSelect && !regWr
    |=> core_clock_out == $past(multClockIn)) else $error("core clock not mult");
endmodule // plt_lock_timer_sva
bind plt_lock_timer plt_lock_timer_sva #(.COUNT_W(COUNT_W), .PRESCALE_DIV(PRESCALE_DIV))
  u_sva (.clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .multClockIn,
  .core_clock_out, .multClockSelect, .lockBusy);

// ===== plt_osc_model.sv
// multiplied clock source, changing every cycle
`timescale 1ns/1ps
module plt_osc_model (
  input wire logic clk,
  output logic multClk
);
  initial multClk = 1'b0;
  // moves off the sampling edge so the synchronous capture is clean
  always @(negedge clk) multClk <= ~multClk;
endmodule // plt_osc_model

// ===== testbench.sv
// self-checking bench of the lock-delay timer
`timescale 1ns/1ps
module testbench;
  logic clk, rst_n, regWr, regRd, rdWas, multClockIn, core_clock_out, multClockSelect, lockBusy;
  logic [15:0] regAddr, regWdata, regRdata, w;
  logic [15:0] expQ[$];
  logic [31:0] seed;
  logic [7:0] n;
  int num_errors, checks_done, cyc, t, i;
  plt_lock_timer u_plt_lock_timer (.clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .multClockIn, .core_clock_out, .multClockSelect, .lockBusy);
  plt_osc_model u_plt_osc_model (.clk, .multClk(multClockIn));
  always #5 clk = ~clk;
  task automatic final_report;
    if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
    regWr <= wr;
    regRd <= !wr;
    regAddr <= a;
    regWdata <= d;
    if (!wr) expQ.push_back(d);
    @(posedge clk);
  endtask
  // strobes drop for one clock, ending a run of back-to-back accesses
  task automatic rel;
    regWr <= 1'b0;
    regRd <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  always @(negedge clk) begin
    if (rdWas) chk(regRdata, expQ.pop_front());
    rdWas = regRd;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report;
    end
  end
  initial begin
    {clk, rst_n, regWr, regRd, rdWas} = 5'h00;
    regAddr = 16'h0000;
    regWdata = 16'h0000;
    seed = 32'h2734f2a8;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    acc(1'b0, 16'h0058, 16'hF003);
    acc(1'b0, 16'h0057, 16'h0000);
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      // count is lockup time over sixteen reference periods
      n = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : {5'h00, seed[2:0]};
      w = {seed[15:11], n, seed[3], 2'b00};
      acc(1'b1, 16'h0058, w);
      acc(1'b0, 16'h0058, w);
      acc(1'b1, 16'h0058, w | 16'h0002);
      rel;
      #1;
      t = 0;
      while (multClockSelect !== 1'b1 && t < 5000) begin
        @(posedge clk);
        #1;
        t++;
      end
      // sixteen reference cycles per count, then one cycle to change over
      chk(16'(t), {4'h0, n, 4'h0});
      @(posedge clk);
      acc(1'b1, 16'h0059, 16'h0000);
      acc(1'b0, 16'h0058, w | 16'h0003);
    end
    rel;
    repeat (2) @(posedge clk);
    final_report;
  end
endmodule // testbench
